// >>> hdl/dac_map.svh
/*
  Register offsets, command bits, reset values and sizes of the DAC
  playback halt / return-to-defaults block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH

// ============================================================
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_RATE 8'h08
`define OFS_POINTS 8'h0C
`define OFS_REPEAT 8'h10
`define OFS_TRIG 8'h14
`define OFS_MEM_ADDR 8'h18
`define OFS_MEM_DATA 8'h1C

// ============================================================
// command register bit positions
`define CMD_SELECT 0
`define CMD_START 1
`define CMD_HALT_SEQ 2
`define CMD_HALT_NOW 3
`define CMD_DEFAULTS 4

// ============================================================
// sizes and reset values
`define SAMPLE_W 16
`define MEM_AW 6
`define PTS_W 7
`define RATE_RESET 16'h0004
`define POINTS_RESET 7'h40
`define REPEAT_RESET 16'h0000
`define TRIG_RESET 1'b0
`define SAMPLE_ZERO 16'h0000
`define FIFO_DEPTH 32

// ============================================================
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> hdl/dac_pkg.sv
/*
  Types shared by the DAC playback control block.
  Assumes dac_map.svh is on the include path.
*/
`include "dac_map.svh"

package dac_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_armed,
    st_run,
    st_gap,
    st_clear
  } play_state_type;

  typedef struct packed {
    logic [15:0] rate;
    logic [`PTS_W-1:0] points;
    logic [15:0] repeat_gap;
    logic trig_ext;
  } play_cfg_type;

  typedef struct packed {
    logic [`MEM_AW-1:0] addr;
    logic [`SAMPLE_W-1:0] data;
  } mem_word_type;

endpackage : dac_pkg

// >>> hdl/dac_playback_abort_reset.sv
/*
  DAC playback control: AXI4-Lite registers, start, halt (after the
  sequence or at the next sample), return to defaults, and a FIFO in
  the sample-load path.
  Assumes one 100 MHz clock aclk, synchronous active-low aresetn, and
  an asynchronous external trigger pin.
*/
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dac_map.svh"

// ============================================================
// fifo
module sample_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

// ============================================================
// playback control
// Summary of operation
// - Halt sends playback to idle and stops all running activity.
// - Halt keeps configuration; a later start repeats the same activity.
// - Halt-after-sequence lets the current sequence end, then idles.
// - The DAC stays selected after a halted activity ends.
// - Return to defaults restores power-on state, DAC stays selected.
// - Return to defaults clears every sample memory word to zero.
// - Return to defaults reloads default sample rate and point count.
// - Return to defaults drives outputs to zero, indices to 0,0.
// - Return to defaults turns the repeat gap off.
// - Outputs hold zero and indices 0,0 until playback restarts.
// - Return to defaults selects the internal trigger.
// - Immediate halt stops playback at the next sample.
module dac_playback_abort_reset
  import dac_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trigger,
  output logic [`SAMPLE_W-1:0] sample_out,
  output logic [`PTS_W-1:0] point_index,
  output logic [15:0] seq_index,
  output logic dac_selected,
  output logic playing
);
  localparam int DEPTH = 1 << `MEM_AW;
  localparam int WW = $bits(mem_word_type);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `OFS_MEM_DATA);
  endfunction : mapped

  // ============================================================
  // state
  play_state_type state;
  play_cfg_type cfg;
  logic [`SAMPLE_W-1:0] mem [DEPTH];
  logic [`MEM_AW-1:0] load_addr;
  logic [`MEM_AW-1:0] clear_addr;
  logic [15:0] div_cnt;
  logic [15:0] gap_cnt;
  logic sample_en;
  logic halt_seq_pend;
  logic halt_now_pend;
  logic [2:0] trig_sync;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic wr_do;
  logic is_cmd;
  logic sel_hit;
  logic start_hit;
  logic halt_seq_hit;
  logic halt_now_hit;
  logic def_hit;
  logic trig_go;
  logic seq_end;
  logic fifo_in_ready;
  logic fifo_out_valid;
  mem_word_type fifo_out;
  mem_word_type fifo_in;

  // ============================================================
  // axi4-lite write side
  // mem_data writes wait for fifo room, which back-pressures the bus
  assign wr_do = aw_held && w_held && !s_axi_bvalid &&
                 ((aw_addr != `OFS_MEM_DATA) || fifo_in_ready);
  assign is_cmd = wr_do && (aw_addr == `OFS_CMD);
  assign sel_hit = is_cmd && w_data[`CMD_SELECT];
  assign start_hit = is_cmd && w_data[`CMD_START] && dac_selected;
  assign halt_seq_hit = is_cmd && w_data[`CMD_HALT_SEQ] && dac_selected;
  assign halt_now_hit = is_cmd && w_data[`CMD_HALT_NOW] && dac_selected;
  assign def_hit = is_cmd && w_data[`CMD_DEFAULTS] && dac_selected;
  assign fifo_in.addr = load_addr;
  assign fifo_in.data = w_data[`SAMPLE_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // configuration is touched only by register writes and defaults
  always_ff @(posedge aclk) begin
    if (!aresetn || def_hit) begin
      cfg.rate <= `RATE_RESET;
      cfg.points <= `POINTS_RESET;
      cfg.repeat_gap <= `REPEAT_RESET;
      cfg.trig_ext <= `TRIG_RESET;
    end else if (wr_do) begin
      case (aw_addr)
        `OFS_RATE: cfg.rate <= w_data[15:0];
        `OFS_POINTS: cfg.points <= w_data[`PTS_W-1:0];
        `OFS_REPEAT: cfg.repeat_gap <= w_data[15:0];
        `OFS_TRIG: cfg.trig_ext <= w_data[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || def_hit) begin
      load_addr <= '0;
    end else if (wr_do && aw_addr == `OFS_MEM_ADDR) begin
      load_addr <= w_data[`MEM_AW-1:0];
    end else if (wr_do && aw_addr == `OFS_MEM_DATA) begin
      load_addr <= load_addr + 1'b1;
    end
  end

  // defaults keep the dac selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_selected <= 1'b0;
    end else if (sel_hit) begin
      dac_selected <= 1'b1;
    end
  end

  // ============================================================
  // axi4-lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_STATUS: s_axi_rdata <= {26'h000_0000, halt_now_pend,
          halt_seq_pend, dac_selected, 3'(state)};
        `OFS_RATE: s_axi_rdata <= {16'h0000, cfg.rate};
        `OFS_POINTS: s_axi_rdata <= {25'h000_0000, cfg.points};
        `OFS_REPEAT: s_axi_rdata <= {16'h0000, cfg.repeat_gap};
        `OFS_TRIG: s_axi_rdata <= {31'h0000_0000, cfg.trig_ext};
        `OFS_MEM_ADDR: s_axi_rdata <= {26'h000_0000, load_addr};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ============================================================
  // sample load path; flushed on defaults so stale loads cannot land
  sample_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) load_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(def_hit),
    .in_valid(wr_do && aw_addr == `OFS_MEM_DATA),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(state != st_clear),
    .out_data(fifo_out)
  );

  always_ff @(posedge aclk) begin
    if (state == st_clear) begin
      mem[clear_addr] <= `SAMPLE_ZERO;
    end else if (fifo_out_valid) begin
      mem[fifo_out.addr] <= fifo_out.data;
    end
  end

  // ============================================================
  // sample rate divider and trigger
  always_ff @(posedge aclk) begin
    if (!aresetn || state == st_idle || state == st_clear) begin
      div_cnt <= 16'h0000;
      sample_en <= 1'b0;
    end else if (div_cnt >= cfg.rate) begin
      div_cnt <= 16'h0000;
      sample_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      sample_en <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sync <= 3'b000;
    end else begin
      trig_sync <= {trig_sync[1:0], ext_trigger};
    end
  end
  assign trig_go = !cfg.trig_ext || (trig_sync[1] && !trig_sync[2]);
  assign seq_end = (point_index >= cfg.points - 1'b1);

  // ============================================================
  // halt requests: a new request beats the clear on start; requests while idle are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn || def_hit) begin
      halt_seq_pend <= 1'b0;
      halt_now_pend <= 1'b0;
    end else begin
      if (halt_seq_hit && state != st_idle) begin
        halt_seq_pend <= 1'b1;
      end else if (state == st_idle || start_hit) begin
        halt_seq_pend <= 1'b0;
      end
      if (halt_now_hit && state != st_idle) begin
        halt_now_pend <= 1'b1;
      end else if (state == st_idle || start_hit) begin
        halt_now_pend <= 1'b0;
      end
    end
  end

  // ============================================================
  // playback state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      clear_addr <= '0;
      gap_cnt <= 16'h0000;
    end else if (def_hit) begin
      state <= st_clear;
      clear_addr <= '0;
    end else begin
      case (state)
        st_idle: if (start_hit) state <= st_armed;
        st_armed: begin
          if (halt_now_pend || halt_seq_pend) begin
            state <= st_idle;
          end else if (trig_go) begin
            state <= st_run;
          end
        end
        st_run: begin
          if (sample_en && halt_now_pend) begin
            state <= st_idle;
          end else if (sample_en && seq_end) begin
            if (halt_seq_pend) begin
              state <= st_idle;
            end else if (cfg.repeat_gap != 16'h0000) begin
              state <= st_gap;
              gap_cnt <= cfg.repeat_gap;
            end
          end
        end
        st_gap: begin
          if (halt_now_pend || halt_seq_pend) begin
            state <= st_idle;
          end else if (sample_en) begin
            gap_cnt <= gap_cnt - 16'h0001;
            if (gap_cnt == 16'h0001) state <= st_run;
          end
        end
        st_clear: begin
          clear_addr <= clear_addr + 1'b1;
          if (clear_addr == `MEM_AW'(DEPTH-1)) state <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // outputs change only while running or on a start from idle, so zeros hold until restart
  always_ff @(posedge aclk) begin
    if (!aresetn || def_hit) begin
      sample_out <= `SAMPLE_ZERO;
      point_index <= '0;
      seq_index <= 16'h0000;
    end else if (start_hit && state == st_idle) begin
      point_index <= '0;
      seq_index <= 16'h0000;
    end else if (state == st_run && sample_en && !halt_now_pend) begin
      sample_out <= mem[point_index[`MEM_AW-1:0]];
      if (seq_end) begin
        point_index <= '0;
        seq_index <= seq_index + 16'h0001;
      end else begin
        point_index <= point_index + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      playing <= 1'b0;
    end else begin
      playing <= !def_hit && (state == st_run || state == st_gap);
    end
  end

  // ============================================================
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_halt_now_stops: assert property (
    state == st_run && sample_en && halt_now_pend && !def_hit
    |=> state == st_idle)
    else $error("immediate halt did not stop at the sample");
  a_halt_seq_waits: assert property (
    state == st_run && halt_seq_pend && !halt_now_pend && !def_hit &&
    !(sample_en && seq_end) |=> state == st_run)
    else $error("halt after sequence stopped early");
  a_halt_keeps_cfg: assert property (
    (halt_seq_hit || halt_now_hit) && !def_hit
    |=> $stable(cfg) ##1 $stable(cfg))
    else $error("halt changed configuration");
  a_halt_keeps_sel: assert property (
    halt_now_hit |=> dac_selected [*3])
    else $error("dac deselected after halt");
  a_idle_halt_noop: assert property (
    state == st_idle && (halt_seq_hit || halt_now_hit) && !def_hit &&
    !start_hit |=> state == st_idle && !halt_now_pend && !halt_seq_pend)
    else $error("halt while idle changed state");
  a_defaults_cfg: assert property (
    def_hit |=> cfg.rate == `RATE_RESET && cfg.points == `POINTS_RESET &&
    cfg.repeat_gap == `REPEAT_RESET && cfg.trig_ext == `TRIG_RESET)
    else $error("defaults not restored");
  a_defaults_zero: assert property (
    def_hit |=> sample_out == `SAMPLE_ZERO && point_index == '0 &&
    seq_index == 16'h0000 && state == st_clear)
    else $error("outputs or indices not zeroed");
  a_defaults_done: assert property (
    def_hit |-> ##[1:70] state == st_idle && dac_selected)
    else $error("defaults did not finish selected");
  a_clear_zero: assert property (
    state == st_clear && !def_hit |=> mem[$past(clear_addr)] == '0)
    else $error("memory word not cleared");
  a_hold_zero: assert property (
    state inside {st_idle, st_armed, st_gap, st_clear} && !def_hit
    |=> $stable(sample_out))
    else $error("output moved while not running");

  c_halt_now: cover property (state == st_run ##1 halt_now_pend
    ##[1:40] state == st_idle);
  c_halt_seq: cover property (halt_seq_pend && state == st_run
    ##[1:300] state == st_idle);
  c_defaults: cover property (state == st_clear ##1 state == st_idle);
  c_restart: cover property (state == st_idle ##1 state == st_armed
    ##[1:20] state == st_run);
endmodule : dac_playback_abort_reset

`default_nettype wire

// >>> testbench/host_model.sv
/*
  Host controller model: AXI4-Lite master issuing one register write
  or read at a time through its tasks.
  Assumes the bench clock aclk; the bench's own timeout ends any hang.
*/
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// host master
module host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // released lines show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : host_model

`default_nettype wire

// >>> testbench/tb_dac_playback_abort_reset.sv
/*
  Self-checking bench of the DAC playback halt / defaults block.
  Assumes host_model as register master and a FIFO depth of 4 so that
  sample loads stall during the memory clear.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dac_map.svh"

// ============================================================
// bench top
module tb_dac_playback_abort_reset;
  import dac_pkg::*;
  localparam logic [31:0] C_SEL = 32'h0000_0001 << `CMD_SELECT;
  localparam logic [31:0] C_START = 32'h0000_0001 << `CMD_START;
  localparam logic [31:0] C_HSEQ = 32'h0000_0001 << `CMD_HALT_SEQ;
  localparam logic [31:0] C_HNOW = 32'h0000_0001 << `CMD_HALT_NOW;
  localparam logic [31:0] C_DEF = 32'h0000_0001 << `CMD_DEFAULTS;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ext_trigger = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [`SAMPLE_W-1:0] sample_out;
  logic [`PTS_W-1:0] point_index;
  logic [15:0] seq_index;
  logic dac_selected, playing;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #5 aclk = ~aclk;

  dac_playback_abort_reset #(.FIFO_DEPTH(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger(ext_trigger), .sample_out(sample_out),
    .point_index(point_index), .seq_index(seq_index),
    .dac_selected(dac_selected), .playing(playing)
  );

  host_model i_host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  // ============================================================
  // helpers
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] exp);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk({30'd0, r}, {30'd0, exp});
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    chk(d, exp);
    chk({30'd0, r}, {30'd0, `RESP_OKAY});
  endtask : rchk

  task automatic wait_idx(input logic [`PTS_W-1:0] v);
    int n;
    for (n = 0; n < 1000 && point_index !== v; n++) @(negedge aclk);
    chk({25'd0, point_index}, {25'd0, v});
  endtask : wait_idx

  task automatic wait_play(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && playing !== lvl; n++) @(negedge aclk);
    chk({31'd0, playing}, {31'd0, lvl});
  endtask : wait_play

  task automatic pulse_trigger();
    @(posedge aclk);
    ext_trigger <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_trigger <= 1'b0;
  endtask : pulse_trigger

  // ============================================================
  // scenarios
  task automatic t_reset_and_load();
    logic [31:0] d;
    logic [1:0] r;
    int i;
    rchk(`OFS_RATE, {16'd0, `RATE_RESET});
    rchk(`OFS_TRIG, 32'h0000_0000);
    i_host.rd(8'h20, d, r);
    chk({30'd0, r}, {30'd0, `RESP_SLVERR});
    wreg(8'h24, 32'h0000_0001, `RESP_SLVERR);
    wreg(`OFS_CMD, C_START, `RESP_OKAY);
    repeat (10) @(negedge aclk);
    chk({31'd0, playing}, 32'h0000_0000);
    wreg(`OFS_CMD, C_SEL, `RESP_OKAY);
    chk({31'd0, dac_selected}, 32'h0000_0001);
    wreg(`OFS_MEM_ADDR, 32'h0000_0000, `RESP_OKAY);
    for (i = 0; i < 8; i++)
      wreg(`OFS_MEM_DATA, 32'h0000_1111 * (i + 1), `RESP_OKAY);
    wreg(`OFS_RATE, 32'h0000_0003, `RESP_OKAY);
    wreg(`OFS_POINTS, 32'h0000_0008, `RESP_OKAY);
    wreg(`OFS_TRIG, 32'h0000_0001, `RESP_OKAY);
    $display("test reset_and_load done");
  endtask : t_reset_and_load

  // start arms, the external trigger runs, then first sample comes from word 0
  task automatic t_start(input logic [15:0] exp1);
    wreg(`OFS_CMD, C_START, `RESP_OKAY);
    repeat (10) @(negedge aclk);
    chk({31'd0, playing}, 32'h0000_0000);
    pulse_trigger();
    wait_play(1'b1, 20);
    wait_idx(7'h01);
    chk({16'd0, sample_out}, {16'd0, exp1});
    $display("test start done");
  endtask : t_start

  task automatic t_halt_now();
    wait_idx(7'h03);
    wreg(`OFS_CMD, C_HNOW, `RESP_OKAY);
    wait_play(1'b0, 8);
    chk({31'd0, point_index >= 3 && point_index <= 5}, 1);
    chk({31'd0, dac_selected}, 32'h0000_0001);
    rchk(`OFS_RATE, 32'h0000_0003);
    rchk(`OFS_POINTS, 32'h0000_0008);
    $display("test halt_now done");
  endtask : t_halt_now

  task automatic t_halt_seq();
    logic [31:0] d;
    logic [1:0] r;
    wait_idx(7'h03);
    wreg(`OFS_CMD, C_HSEQ, `RESP_OKAY);
    repeat (6) @(negedge aclk);
    chk({31'd0, playing}, 32'h0000_0001);
    wait_play(1'b0, 40);
    chk({25'd0, point_index}, 32'h0000_0000);
    chk({16'd0, seq_index}, 32'h0000_0001);
    i_host.rd(`OFS_STATUS, d, r);
    chk(d & 32'h0000_000f, 32'h0000_0008);
    wreg(`OFS_CMD, C_HSEQ | C_HNOW, `RESP_OKAY);
    i_host.rd(`OFS_STATUS, d, r);
    chk(d & 32'h0000_003f, 32'h0000_0008);
    rchk(`OFS_RATE, 32'h0000_0003);
    $display("test halt_seq done");
  endtask : t_halt_seq

  // loads during the clear stall on the 4-deep FIFO
  task automatic t_defaults();
    int i;
    wreg(`OFS_REPEAT, 32'h0000_0005, `RESP_OKAY);
    // gap of 5 samples after the 8-point sequence; defaults hit in the gap
    wreg(`OFS_CMD, C_START, `RESP_OKAY);
    pulse_trigger();
    wait_idx(7'h07);
    repeat (12) @(negedge aclk);
    chk({25'd0, point_index}, 32'h0000_0000);
    chk({31'd0, playing}, 32'h0000_0001);
    wreg(`OFS_CMD, C_DEF, `RESP_OKAY);
    wreg(`OFS_MEM_ADDR, 32'h0000_0000, `RESP_OKAY);
    for (i = 0; i < 6; i++)
      wreg(`OFS_MEM_DATA, 32'h0000_0a00 + i, `RESP_OKAY);
    repeat (80) @(negedge aclk);
    chk({16'd0, sample_out}, {16'd0, `SAMPLE_ZERO});
    chk({25'd0, point_index}, 32'h0000_0000);
    chk({16'd0, seq_index}, 32'h0000_0000);
    chk({31'd0, dac_selected}, 32'h0000_0001);
    rchk(`OFS_RATE, {16'd0, `RATE_RESET});
    rchk(`OFS_POINTS, {25'd0, `POINTS_RESET});
    rchk(`OFS_REPEAT, {16'd0, `REPEAT_RESET});
    rchk(`OFS_TRIG, {31'd0, `TRIG_RESET});
    wreg(`OFS_CMD, C_START, `RESP_OKAY);
    wait_play(1'b1, 20);
    wait_idx(7'h02);
    chk({16'd0, sample_out}, 32'h0000_0a01);
    wait_idx(7'h08);
    chk({16'd0, sample_out}, {16'd0, `SAMPLE_ZERO});
    wreg(`OFS_CMD, C_HNOW, `RESP_OKAY);
    wait_play(1'b0, 10);
    $display("test defaults done");
  endtask : t_defaults

  // ============================================================
  // sequence and timeout
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_and_load();
    t_start(16'h1111);
    t_halt_now();
    t_start(16'h1111);
    t_halt_seq();
    t_defaults();
    end_sim();
  end
endmodule : tb_dac_playback_abort_reset

`default_nettype wire
